/* File: epm_pkg.sv */
package epm_pkg;

  // Timing
  localparam int CLK_FREQ_MHZ    = 250;
  localparam int EE_SK_FREQ_KHZ  = 2000;
  localparam int EE_SK_HALF_CYC  = (CLK_FREQ_MHZ * 1000 + 2 * EE_SK_FREQ_KHZ - 1)
                                   / (2 * EE_SK_FREQ_KHZ);
  localparam logic [7:0] EE_HALF_LAST = 8'(EE_SK_HALF_CYC - 1);

  // Serial read command framing
  localparam logic [2:0] EE_CMD_READ   = 3'h6;
  localparam logic [4:0] EE_FIRST_IN   = 5'h09;
  localparam logic [4:0] EE_LAST_BIT   = 5'h19;

  // EEPROM word and byte addresses
  localparam logic [5:0] EE_WA_SIG     = 6'h00;
  localparam logic [5:0] EE_WA_REGION  = 6'h01;
  localparam logic [7:0] EE_BA_CHIPCTL = 8'h08;
  localparam logic [7:0] EE_BA_EXTCTL  = 8'h0E;
  localparam logic [7:0] EE_BA_PMCAP   = 8'h10;
  localparam logic [7:0] EE_BA_PMDATA  = 8'h12;
  localparam logic [1:0] EE_WORD_LAST  = 2'h3;

  // Region enable codes
  localparam logic [3:0] REGION_ALL    = 4'hF;
  localparam logic [3:0] REGION_STOP11 = 4'h7;
  localparam logic [7:0] REGION_BA11   = 8'h11;
  localparam logic [7:0] REGION_BASE   = 8'h02;
  localparam int         REGION_LO     = 1;

  // Register byte offsets
  localparam logic [9:0] OFS_CHIP40    = 10'h040;
  localparam logic [9:0] OFS_EXT48     = 10'h048;
  localparam logic [9:0] OFS_ARB4C     = 10'h04C;
  localparam logic [9:0] OFS_PMCAP     = 10'h080;
  localparam logic [9:0] OFS_PMDATA    = 10'h084;
  localparam logic [9:0] OFS_TEST_C0   = 10'h0C0;
  localparam logic [9:0] OFS_STAT_C8   = 10'h0C8;
  localparam logic [9:0] OFS_OWNCTL    = 10'h0D4;
  localparam logic [9:0] OFS_OWNSTAT   = 10'h0D8;

  // Register field positions
  localparam int C0_ISA       = 8;
  localparam int R40_WRDISC   = 1;
  localparam int R40_SINGLEDW = 4;
  localparam int R40_MINFREE  = 9;
  localparam int R40_REORDER  = 10;
  localparam int R4C_PREEMPT  = 28;
  localparam int C8_SUCCESS   = 3;
  localparam int OWN_DUALPOST = 0;
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_SIGFAIL   = 1;
  localparam int ST_BUSY      = 2;

  // EEPROM byte field positions
  localparam int B9_ISA       = 0;
  localparam int B9_WRDISC    = 2;
  localparam int B9_SINGLEDW  = 3;
  localparam int B9_MINFREE   = 4;
  localparam int B9_REORDER   = 5;
  localparam int B9_DUALPOST  = 7;
  localparam int BF_PREEMPT   = 12;

  // Writable masks and reset values
  localparam logic [31:0] MASK_C0     = 32'h0000_0100;
  localparam logic [31:0] MASK_40     = 32'h0000_0E12;
  localparam logic [31:0] MASK_48     = 32'h0000_001F;
  localparam logic [31:0] MASK_4C     = 32'hF000_0000;
  localparam logic [31:0] MASK_OWNCTL = 32'h0000_0001;
  localparam logic [31:0] RST_REG     = 32'h0000_0000;
  localparam logic [7:0]  RST_PMDATA  = 8'h00;

  // Power management capability (fixed read-only values)
  localparam logic [7:0]  PM_CAP_ID    = 8'h01;
  localparam logic [7:0]  PM_NEXT_PTR  = 8'h00;
  localparam logic [15:0] PM_CAP_FIXED = 16'h0602;

  typedef enum logic [4:0] {
    LD_START  = 5'h01,
    LD_SIG    = 5'h02,
    LD_REGION = 5'h04,
    LD_WORDS  = 5'h08,
    LD_DONE   = 5'h10
  } epm_ld_state_t;

  typedef enum logic [2:0] {
    RD_IDLE  = 3'h1,
    RD_SHIFT = 3'h2,
    RD_GAP   = 3'h4
  } epm_rd_state_t;

  typedef struct packed {
    logic       isaEnable;
    logic       wrDisconnect;
    logic       singleDwRead;
    logic       burstMinFree;
    logic [1:0] reorderMode;
    logic [2:0] dtrReorderDepth;
    logic [1:0] postedWriteSlots;
    logic       flowThrough;
    logic       parkOnBridge;
    logic       dsPrefetchDynOff;
    logic       usPrefetchDynOff;
    logic       underflowCtl;
    logic       preemptOn;
    logic [6:0] preemptDelay;
  } epm_ctrl_t;

endpackage

/* File: epm_serial_reader.sv */
`timescale 1ns/1ns
`default_nettype none
module epm_serial_reader
  import epm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstnSync,
  // Word request
  input  wire logic        start,
  input  wire logic [5:0]  wordAddr,
  output logic             busy,
  output logic             done,
  output logic [15:0]      data,
  // EEPROM pins
  output logic             eeCs,
  output logic             eeSk,
  output logic             eeDi,
  input  wire logic        eeDo
);

  epm_rd_state_t state;
  logic [7:0]    phase;
  logic [4:0]    bitIdx;
  logic [8:0]    cmdShift;
  logic          doMeta;
  logic          doSync;

  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      doMeta <= 1'b0;
      doSync <= 1'b0;
    end else begin
      doMeta <= eeDo;
      doSync <= doMeta;
    end
  end

  // Address goes out MSB first on falling SK, held steady for rising SK; data is taken LSB first on falling SK
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      state    <= RD_IDLE;
      phase    <= 8'h00;
      bitIdx   <= 5'h00;
      cmdShift <= 9'h000;
      busy     <= 1'b0;
      done     <= 1'b0;
      data     <= 16'h0000;
      eeCs     <= 1'b0;
      eeSk     <= 1'b0;
      eeDi     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        RD_IDLE: begin
          if (start) begin
            state    <= RD_SHIFT;
            busy     <= 1'b1;
            eeCs     <= 1'b1;
            eeDi     <= EE_CMD_READ[2];
            cmdShift <= {EE_CMD_READ[1:0], wordAddr, 1'b0};
            phase    <= 8'h00;
            bitIdx   <= 5'h00;
          end
        end
        RD_SHIFT: begin
          if (phase == EE_HALF_LAST) begin
            phase <= 8'h00;
            eeSk  <= ~eeSk;
            if (eeSk) begin
              if (bitIdx >= EE_FIRST_IN) begin
                data <= {doSync, data[15:1]};
              end
              if (bitIdx == EE_LAST_BIT) begin
                state <= RD_GAP;
                eeCs  <= 1'b0;
                eeDi  <= 1'b0;
                done  <= 1'b1;
              end else begin
                bitIdx   <= bitIdx + 5'h01;
                eeDi     <= cmdShift[8];
                cmdShift <= {cmdShift[7:0], 1'b0};
              end
            end
          end else begin
            phase <= phase + 8'h01;
          end
        end
        RD_GAP: begin
          // Chip select must stay low a while between words
          if (phase == EE_HALF_LAST) begin
            phase <= 8'h00;
            state <= RD_IDLE;
            busy  <= 1'b0;
          end else begin
            phase <= phase + 8'h01;
          end
        end
        default: begin
          state <= RD_IDLE;
          busy  <= 1'b0;
          eeCs  <= 1'b0;
          eeSk  <= 1'b0;
        end
      endcase
    end
  end

endmodule // epm_serial_reader
`default_nettype wire

/* File: epm_preload_map.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - EEPROM byte 9 bit 0 loads legacy ISA enable into C0h bit 8.
// - Byte 9 bit 2 makes memory writes disconnect at cache line boundaries.
// - Byte 9 bit 3 limits upstream reads to one dword, byte enables forwarded.
// - Byte 9 bit 4 accepts burst writes with one free data FIFO entry.
// - Byte 9 bits 6:5 choose delayed-transaction reorder freedom, four down to one.
// - Byte 9 bit 7 allows two accepted memory writes at once.
// - Byte 0Eh bit 0 loads read flow-through enable into 48h bit 0.
// - Byte 0Eh bit 1 parks secondary grant on the bridge when idle.
// - Byte 0Eh bits 2 and 3 disable dynamic prefetch, downstream and upstream.
// - Byte 0Eh bit 4 enables read underflow handling, held in 48h bit 4.
// - Byte 0Fh bits 7:4 load 4Ch bits 31:28; top bit set disables pre-emption.
// - Codes 0 to 7 give pre-emption after 0,1,2,4,8,16,32,64 clocks.
// - Power management capability at 80h reads version 010.
// - Capability bit 5 reads zero; reserved bits carry nothing.
// - Capability bits 9 and 10 read one for D1 and D2 support.
// - Capability bits 14:11 read zero, no PME generation.
// - Byte 13h lands read-only in 84h bits 31:24; byte 12h unused.
// - Autoload continues only when the first word matches the signature.
// - Region enable bits 4:1 of byte 2 limit how far loading goes.
// - Words are read singly, address MSB first, data LSB first.
module epm_preload_map
  import epm_pkg::*;
#(
  // Expected first word; value is arbitrary
  parameter logic [15:0] SIG_WORD = 16'hA55A
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Avalon-MM slave, word addressed
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // EEPROM pins
  output logic             eeCs,
  output logic             eeSk,
  output logic             eeDi,
  input  wire logic        eeDo,
  // Bridge core controls
  output epm_ctrl_t        bridgeCtrl,
  // Loader status
  output logic             loadDone,
  output logic             loadOk
);

  logic [1:0]    rstPipe;
  logic          rstnSync;
  epm_ld_state_t ldState;
  logic          rdStart;
  logic [5:0]    rdAddr;
  logic          rdBusy;
  logic          rdDone;
  logic [15:0]   rdData;
  logic [3:0]    regionCode;
  logic [1:0]    wordIdx;
  logic          waitWord;
  logic          sigFail;
  logic [31:0]   regC0;
  logic [31:0]   reg40;
  logic [31:0]   reg48;
  logic [31:0]   reg4C;
  logic [31:0]   regOwnCtl;
  logic [7:0]    pmData;
  logic [31:0]   rdMux;
  logic          busWrite;
  logic [31:0]   wrMask;
  logic [9:0]    byteAddr;
  logic [7:0]    wordBa;

  function automatic logic [31:0] mergeBits(input logic [31:0] old,
                                            input logic [31:0] val,
                                            input logic [31:0] mask);
    mergeBits = (old & ~mask) | (val & mask);
  endfunction

  function automatic logic [7:0] wordByteAddr(input logic [1:0] idx);
    case (idx)
      2'h0:    wordByteAddr = EE_BA_CHIPCTL;
      2'h1:    wordByteAddr = EE_BA_EXTCTL;
      2'h2:    wordByteAddr = EE_BA_PMCAP;
      default: wordByteAddr = EE_BA_PMDATA;
    endcase
  endfunction

  // Undefined codes with the top bit set stop at once rather than load blindly
  function automatic logic inRegion(input logic [3:0] code, input logic [7:0] ba);
    if (code == REGION_ALL) begin
      inRegion = 1'b1;
    end else if (code == REGION_STOP11) begin
      inRegion = ba < REGION_BA11;
    end else if (code[3]) begin
      inRegion = 1'b0;
    end else begin
      inRegion = ba < ({3'h0, code, 1'b0} + REGION_BASE);
    end
  endfunction

  function automatic logic [2:0] reorderDepth(input logic [1:0] mode);
    case (mode)
      2'h0:    reorderDepth = 3'h4;
      2'h1:    reorderDepth = 3'h3;
      2'h2:    reorderDepth = 3'h2;
      default: reorderDepth = 3'h1;
    endcase
  endfunction

  function automatic logic [6:0] preemptCycles(input logic [3:0] code);
    case (code[2:0])
      3'h0:    preemptCycles = 7'h00;
      3'h1:    preemptCycles = 7'h01;
      3'h2:    preemptCycles = 7'h02;
      3'h3:    preemptCycles = 7'h04;
      3'h4:    preemptCycles = 7'h08;
      3'h5:    preemptCycles = 7'h10;
      3'h6:    preemptCycles = 7'h20;
      default: preemptCycles = 7'h40;
    endcase
  endfunction

  // Byte 9 bits land at scattered positions of the 40h register
  function automatic logic [31:0] map40(input logic [7:0] b9);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[R40_WRDISC]         = b9[B9_WRDISC];
    v[R40_SINGLEDW]       = b9[B9_SINGLEDW];
    v[R40_MINFREE]        = b9[B9_MINFREE];
    v[R40_REORDER +: 2]   = b9[B9_REORDER +: 2];
    map40 = v;
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstnSync = rstPipe[1];

  epm_serial_reader u_reader (
    .core_clk (core_clk),
    .rstnSync (rstnSync),
    .start    (rdStart),
    .wordAddr (rdAddr),
    .busy     (rdBusy),
    .done     (rdDone),
    .data     (rdData),
    .eeCs     (eeCs),
    .eeSk     (eeSk),
    .eeDi     (eeDi),
    .eeDo     (eeDo)
  );

  assign wordBa = wordByteAddr(wordIdx);

  // Loader sequence
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ldState    <= LD_START;
      rdStart    <= 1'b0;
      rdAddr     <= 6'h00;
      regionCode <= 4'h0;
      wordIdx    <= 2'h0;
      waitWord   <= 1'b0;
      sigFail    <= 1'b0;
      loadDone   <= 1'b0;
      loadOk     <= 1'b0;
    end else begin
      rdStart <= 1'b0;
      case (ldState)
        LD_START: begin
          if (!rdBusy && !rdStart) begin
            rdStart <= 1'b1;
            rdAddr  <= EE_WA_SIG;
            ldState <= LD_SIG;
          end
        end
        LD_SIG: begin
          if (rdDone) begin
            if (rdData == SIG_WORD) begin
              ldState <= LD_REGION;
            end else begin
              sigFail  <= 1'b1;
              loadDone <= 1'b1;
              ldState  <= LD_DONE;
            end
          end
        end
        LD_REGION: begin
          if (!rdBusy && !rdStart && !waitWord) begin
            rdStart  <= 1'b1;
            rdAddr   <= EE_WA_REGION;
            waitWord <= 1'b1;
          end else if (rdDone) begin
            regionCode <= rdData[REGION_LO +: 4];
            waitWord   <= 1'b0;
            wordIdx    <= 2'h0;
            ldState    <= LD_WORDS;
          end
        end
        LD_WORDS: begin
          if (!waitWord && !rdBusy && !rdStart) begin
            if (inRegion(regionCode, wordBa)) begin
              rdStart  <= 1'b1;
              rdAddr   <= wordBa[6:1];
              waitWord <= 1'b1;
            end else begin
              loadDone <= 1'b1;
              loadOk   <= 1'b1;
              ldState  <= LD_DONE;
            end
          end else if (rdDone) begin
            waitWord <= 1'b0;
            if (wordIdx == EE_WORD_LAST) begin
              loadDone <= 1'b1;
              loadOk   <= 1'b1;
              ldState  <= LD_DONE;
            end else begin
              wordIdx <= wordIdx + 2'h1;
            end
          end
        end
        LD_DONE: begin
          loadDone <= 1'b1;
        end
        default: begin
          ldState <= LD_DONE;
        end
      endcase
    end
  end

  assign byteAddr = {address, 2'h0};
  // A write lands only at the edge where waitrequest is seen low
  assign busWrite = write && !waitrequest;
  assign wrMask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

  // Autoload and software writes share one process; the bus is held off while loading
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      regC0     <= RST_REG;
      reg40     <= RST_REG;
      reg48     <= RST_REG;
      reg4C     <= RST_REG;
      regOwnCtl <= RST_REG;
      pmData    <= RST_PMDATA;
    end else if (rdDone && ldState == LD_WORDS) begin
      case (wordBa)
        EE_BA_CHIPCTL: begin
          regC0     <= mergeBits(regC0, 32'(rdData[8 + B9_ISA]) << C0_ISA, MASK_C0);
          reg40     <= mergeBits(reg40, map40(rdData[15:8]), MASK_40);
          regOwnCtl <= mergeBits(regOwnCtl, 32'(rdData[8 + B9_DUALPOST]), MASK_OWNCTL);
        end
        EE_BA_EXTCTL: begin
          reg48 <= mergeBits(reg48, {27'h0, rdData[4:0]}, MASK_48);
          reg4C <= mergeBits(reg4C, {rdData[BF_PREEMPT +: 4], 28'h0}, MASK_4C);
        end
        EE_BA_PMDATA: begin
          pmData <= rdData[15:8];
        end
        default: begin
          // Capability word fields are fixed; loaded bits are discarded
          pmData <= pmData;
        end
      endcase
    end else if (busWrite) begin
      case (byteAddr)
        OFS_TEST_C0: regC0     <= mergeBits(regC0, writedata, MASK_C0 & wrMask);
        OFS_CHIP40:  reg40     <= mergeBits(reg40, writedata, MASK_40 & wrMask);
        OFS_EXT48:   reg48     <= mergeBits(reg48, writedata, MASK_48 & wrMask);
        OFS_ARB4C:   reg4C     <= mergeBits(reg4C, writedata, MASK_4C & wrMask);
        OFS_OWNCTL:  regOwnCtl <= mergeBits(regOwnCtl, writedata, MASK_OWNCTL & wrMask);
        default:     pmData    <= pmData;
      endcase
    end
  end

  // Reserved and unmapped offsets read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (byteAddr)
      OFS_TEST_C0: rdMux = regC0;
      OFS_CHIP40:  rdMux = reg40;
      OFS_EXT48:   rdMux = reg48;
      OFS_ARB4C:   rdMux = reg4C;
      OFS_PMCAP:   rdMux = {PM_CAP_FIXED, PM_NEXT_PTR, PM_CAP_ID};
      OFS_PMDATA:  rdMux = {pmData, 24'h00_0000};
      OFS_STAT_C8: rdMux = 32'(loadOk) << C8_SUCCESS;
      OFS_OWNCTL:  rdMux = regOwnCtl;
      OFS_OWNSTAT: rdMux = (32'(loadDone) << ST_DONE_BIT) | (32'(sigFail) << ST_SIGFAIL)
                           | (32'(!loadDone) << ST_BUSY);
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  // Every access sees one wait cycle; none is answered until loading ends
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && loadDone) begin
      waitrequest <= 1'b0;
      readdata    <= read ? rdMux : 32'h0000_0000;
    end
  end

  // Controls lag the registers by one cycle so the core sees a registered copy
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      bridgeCtrl <= '0;
    end else begin
      bridgeCtrl.isaEnable        <= regC0[C0_ISA];
      bridgeCtrl.wrDisconnect     <= reg40[R40_WRDISC];
      bridgeCtrl.singleDwRead     <= reg40[R40_SINGLEDW];
      bridgeCtrl.burstMinFree     <= reg40[R40_MINFREE];
      bridgeCtrl.reorderMode      <= reg40[R40_REORDER +: 2];
      bridgeCtrl.dtrReorderDepth  <= reorderDepth(reg40[R40_REORDER +: 2]);
      bridgeCtrl.postedWriteSlots <= regOwnCtl[OWN_DUALPOST] ? 2'h2 : 2'h1;
      bridgeCtrl.flowThrough      <= reg48[0];
      bridgeCtrl.parkOnBridge     <= reg48[1];
      bridgeCtrl.dsPrefetchDynOff <= reg48[2];
      bridgeCtrl.usPrefetchDynOff <= reg48[3];
      bridgeCtrl.underflowCtl     <= reg48[4];
      bridgeCtrl.preemptOn        <= !reg4C[R4C_PREEMPT + 3];
      bridgeCtrl.preemptDelay     <= preemptCycles(reg4C[R4C_PREEMPT +: 4]);
    end
  end

endmodule // epm_preload_map
`default_nettype wire

/* File: epm_preload_map_props.sv */
`timescale 1ns/1ns
`default_nettype none
module epm_preload_map_props
  import epm_pkg::*;
(
  // Clock and reset
  input wire logic      core_clk,
  input wire logic      rstn,
  // Register bus
  input wire logic      read,
  input wire logic      write,
  input wire logic      waitrequest,
  // EEPROM pins
  input wire logic      eeCs,
  input wire logic      eeSk,
  input wire logic      eeDi,
  // Controls and status
  input wire epm_ctrl_t bridgeCtrl,
  input wire logic      loadDone,
  input wire logic      loadOk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_wait_after_load: assert property (!waitrequest |-> loadDone)
    else $error("bus answered before load finished");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answer: assert property ((read || write) && waitrequest && loadDone |=> !waitrequest)
    else $error("taken request not answered next cycle");
  a_ok_needs_done: assert property (loadOk |-> loadDone)
    else $error("load success without load finished");
  a_done_holds: assert property (loadDone |=> loadDone)
    else $error("load finished flag dropped");
  a_reorder_depth: assert property (loadDone |->
    bridgeCtrl.dtrReorderDepth == 3'(4 - bridgeCtrl.reorderMode))
    else $error("reorder depth does not follow mode");
  a_preempt_power: assert property (loadDone && bridgeCtrl.preemptOn |->
    $onehot0(bridgeCtrl.preemptDelay))
    else $error("pre-emption delay not a listed value");
  a_frame_start: assert property ($rose(eeCs) |-> eeDi && !eeSk)
    else $error("serial frame does not start with a one and clock low");
  a_sk_in_frame: assert property (eeSk |-> eeCs)
    else $error("serial clock high outside a frame");
  a_di_steady: assert property ($rose(eeSk) |-> $stable(eeDi))
    else $error("serial data moved at clock rise");
  a_cs_whole: assert property ($rose(eeCs) |=> eeCs [*8])
    else $error("chip select dropped early");
endmodule // epm_preload_map_props

bind epm_preload_map epm_preload_map_props u_props (
  .core_clk(core_clk), .rstn(rstn), .read(read), .write(write),
  .waitrequest(waitrequest), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi),
  .bridgeCtrl(bridgeCtrl), .loadDone(loadDone), .loadOk(loadOk));
`default_nettype wire

/* File: epm_eeprom_model.sv */
`timescale 1ns/1ns
`default_nettype none
module epm_eeprom_model (
  // Clock
  input  wire logic core_clk,
  // EEPROM pins
  input  wire logic eeCs,
  input  wire logic eeSk,
  input  wire logic eeDi,
  output logic      eeDo,
  // Bad command count
  output int        cmdErrs
);
  logic [15:0] mem [0:63];
  logic [8:0]  hdr    = 9'h000;
  logic [4:0]  bitIdx = 5'h00;
  logic        skPrev = 1'b0;
  logic        doBit  = 1'b0;

  // One driver for the pin; the count starts at zero by its type
  assign eeDo = doBit;

  always @(posedge core_clk) begin
    skPrev <= eeSk;
    if (!eeCs) begin
      bitIdx <= 5'h00;
      // Deselected line keeps changing so a stale bit cannot pass
      doBit <= ~doBit;
    end else if (eeSk && !skPrev) begin
      bitIdx <= bitIdx + 5'h01;
      if (bitIdx < 5'h09) hdr <= {hdr[7:0], eeDi};
      if (bitIdx == 5'h09) begin
        doBit <= 1'b0;
        if (hdr[8:6] !== 3'b110) cmdErrs <= cmdErrs + 1;
      end
      if (bitIdx > 5'h09) doBit <= mem[hdr[5:0]][4'(bitIdx - 5'h0A)];
    end
  end
endmodule // epm_eeprom_model
`default_nettype wire

/* File: test_eeprom_config_preload_map.sv */
`timescale 1ns/1ns
`default_nettype none
module test_eeprom_config_preload_map
  import epm_pkg::*;
();
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] v;
  } epm_row_t;

  // Arbitrary signature value
  localparam logic [15:0] SIG = 16'h3C3C;

  logic        core_clk, rstn, read, write, waitrequest;
  logic        eeCs, eeSk, eeDi, eeDo, loadDone, loadOk;
  logic [7:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  epm_ctrl_t   bridgeCtrl, expCtrl;
  int          miscompares = 0;
  int          compares = 0;
  int          cmdErrs;

  epm_row_t rows [10] = '{
    '{8'h10, 32'h0000_0A02}, '{8'h12, 32'h0000_000D}, '{8'h13, 32'h5000_0000},
    '{8'h20, 32'h0602_0001}, '{8'h21, 32'h9C00_0000}, '{8'h30, 32'h0000_0100},
    '{8'h32, 32'h0000_0008}, '{8'h35, 32'h0000_0001}, '{8'h36, 32'h0000_0001},
    '{8'h3F, 32'h0000_0000}};

  epm_preload_map #(.SIG_WORD(SIG)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo),
    .bridgeCtrl(bridgeCtrl), .loadDone(loadDone), .loadOk(loadOk));

  epm_eeprom_model u_ee (
    .core_clk(core_clk), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo),
    .cmdErrs(cmdErrs));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is seen low; the load may stall it long
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 30000);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 30000) miscompares++;
  endtask

  task automatic reload(input logic [15:0] w0, input logic [15:0] w1);
    u_ee.mem[0] = w0;
    u_ee.mem[1] = w1;
    rstn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
  endtask

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    for (int i = 0; i < 64; i++) u_ee.mem[i] = 16'hFFFF;
    u_ee.mem[4] = 16'hD7FF;
    u_ee.mem[7] = 16'h5FED;
    u_ee.mem[9] = 16'h9CFF;
    reload(SIG, 16'h001F);
    foreach (rows[i]) begin
      access(1'b0, rows[i].a, 32'h0, 4'hF);
      check("register", rows[i].v, rd);
    end
    expCtrl = '{1'b1, 1'b1, 1'b0, 1'b1, 2'b10, 3'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                1'b1, 7'h10};
    check("bridgeCtrl", 32'(expCtrl), 32'(bridgeCtrl));
    for (int m = 0; m < 4; m++) begin
      access(1'b1, 8'h10, 32'(m) << 10, 4'hF);
      repeat (2) @(posedge core_clk);
      check("reorder depth", 32'(4 - m), 32'(bridgeCtrl.dtrReorderDepth));
    end
    access(1'b1, 8'h10, 32'h0000_0010, 4'hF);
    access(1'b1, 8'h12, 32'h0000_0012, 4'hF);
    repeat (2) @(posedge core_clk);
    check("written controls", 32'h7,
          32'({bridgeCtrl.singleDwRead, bridgeCtrl.parkOnBridge, bridgeCtrl.underflowCtl}));
    for (int k = 0; k < 9; k++) begin
      access(1'b1, 8'h13, 32'(k) << 28, 4'hF);
      repeat (2) @(posedge core_clk);
      check("pre-emption", (k < 8) ? {24'h0, 1'b1, 7'((1 << k) >> 1)} : 32'h0,
            (k < 8) ? 32'({bridgeCtrl.preemptOn, bridgeCtrl.preemptDelay})
                    : 32'(bridgeCtrl.preemptOn));
    end
    access(1'b1, 8'h13, 32'hF000_0000, 4'h7);
    access(1'b0, 8'h13, 32'h0, 4'hF);
    check("masked byte write", 32'h8000_0000, rd);
    access(1'b1, 8'h20, 32'h0, 4'hF);
    access(1'b0, 8'h20, 32'h0, 4'hF);
    check("capability write", 32'h0602_0001, rd);
    reload(~SIG, 16'h001F);
    access(1'b0, 8'h32, 32'h0, 4'hF);
    check("bad signature", 32'h0, {rd[31:1], loadOk});
    expCtrl = '{1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 3'h4, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                1'b1, 7'h00};
    check("reset controls", 32'(expCtrl), 32'(bridgeCtrl));
    access(1'b0, 8'h30, 32'h0, 4'hF);
    check("bad signature load", 32'h0, rd);
    reload(SIG, 16'h000F);
    access(1'b0, 8'h21, 32'h0, 4'hF);
    check("region stop data", 32'h0, rd);
    access(1'b0, 8'h12, 32'h0, 4'hF);
    check("region stop ext", 32'h0000_000D, rd);
    reload(SIG, 16'h0008);
    access(1'b0, 8'h30, 32'h0, 4'hF);
    check("region 0100 chip", 32'h0000_0100, rd);
    access(1'b0, 8'h12, 32'h0, 4'hF);
    check("region 0100 ext", 32'h0, rd);
    reload(SIG, 16'h0012);
    access(1'b0, 8'h32, 32'h0, 4'hF);
    check("region 1001 ok", 32'h0000_0008, rd);
    access(1'b0, 8'h30, 32'h0, 4'hF);
    check("region 1001 chip", 32'h0, rd);
    check("serial command", 32'h0, 32'(cmdErrs));
    summarize();
  end

  initial begin
    #300000;
    miscompares++;
    summarize();
  end
endmodule // test_eeprom_config_preload_map
`default_nettype wire
